// file: fspi_pkg.sv
/*
  Shared constants for the serial memory pin interface: array geometry,
  command codes, status bit positions and the read buffer depth.
  Assumes nothing of its surroundings; it is imported by fspi_top and the bench.
*/
package fspi_pkg;

  // ==========================================================================
  // Array geometry
  localparam int ADDR_W     = 19;  // 524,288 locations.
  localparam int DATA_W     = 8;   // One byte per location.
  localparam int ADDR_BYTES = 3;   // Address bytes sent by the master.
  localparam int FIFO_DEPTH = 4;   // Read prefetch buffer words.

  // ==========================================================================
  // Command codes
  localparam logic [7:0] OP_WREN  = 8'h06;
  localparam logic [7:0] OP_WRDI  = 8'h04;
  localparam logic [7:0] OP_RDSR  = 8'h05;
  localparam logic [7:0] OP_WRSR  = 8'h01;
  localparam logic [7:0] OP_READ  = 8'h03;
  localparam logic [7:0] OP_WRITE = 8'h02;

  // ==========================================================================
  // Status register layout
  localparam int         STAT_GUARD_BIT = 7;      // status_write_guard_enable.
  localparam int         STAT_WEL_BIT   = 1;      // Write enable latch.
  localparam logic [7:0] STAT_WR_MASK   = 8'h8c;  // Bits software may write.
  localparam logic [7:0] STAT_RESET     = 8'h00;

  // ==========================================================================
  // Frame phases
  typedef enum logic [2:0] {
    FSPI_IDLE,
    FSPI_OPCODE,
    FSPI_ADDR,
    FSPI_WDATA,
    FSPI_RDATA,
    FSPI_SRWR,
    FSPI_SRRD,
    FSPI_IGNORE
  } fspi_phase_t;

endpackage

// file: fspi_fifo.sv
/*
  Small show-ahead FIFO with valid/ready on both sides and a clear input.
  Assumes one clock, a synchronous active-high reset and a clock enable.
*/
`timescale 1ns/1ns
`default_nettype none

module fspi_fifo #(
  parameter int W = 8,
  parameter int D = 4
) (
  // Clock and control
  input  wire logic         clk_in,
  input  wire logic         rst_in,
  input  wire logic         ce_in,
  input  wire logic         clr_in,
  // Filling side
  input  wire logic         in_valid_in,
  output logic              in_ready_out,
  input  wire logic [W-1:0] in_data_in,
  // Draining side
  output logic              out_valid_out,
  input  wire logic         out_ready_in,
  output logic [W-1:0]      out_data_out
);

  localparam int PW = (D > 1) ? $clog2(D) : 1;

  logic [W-1:0] mem_r [D];
  logic [PW-1:0] wptr_r, wptr_nxt, rptr_r, rptr_nxt;
  logic [PW:0]   cnt_r, cnt_nxt;
  logic          push, pop;

  // ==========================================================================
  // Pointer arithmetic
  // Pointers wrap at the depth, so a depth that is not a power of two works.
  function automatic logic [PW-1:0] inc_ptr(input logic [PW-1:0] p);
    return (p == PW'(D - 1)) ? '0 : p + 1'b1;
  endfunction

  assign in_ready_out  = (cnt_r != (PW+1)'(D));
  assign out_valid_out = (cnt_r != '0);
  assign out_data_out  = mem_r[rptr_r];
  assign push          = in_valid_in && in_ready_out;
  assign pop           = out_valid_out && out_ready_in;

  // Next pointers and count; clear wins over any push or pop.
  always_comb begin
    wptr_nxt = push ? inc_ptr(wptr_r) : wptr_r;
    rptr_nxt = pop ? inc_ptr(rptr_r) : rptr_r;
    cnt_nxt  = cnt_r + (PW+1)'(push) - (PW+1)'(pop);
    if (clr_in) begin
      wptr_nxt = '0;
      rptr_nxt = '0;
      cnt_nxt  = '0;
    end
  end

  // Registers only; the array holds no reset since the count guards it.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      wptr_r <= '0;
      rptr_r <= '0;
      cnt_r  <= '0;
    end else if (ce_in) begin
      wptr_r <= wptr_nxt;
      rptr_r <= rptr_nxt;
      cnt_r  <= cnt_nxt;
      if (push && !clr_in) begin
        mem_r[wptr_r] <= in_data_in;
      end
    end
  end

endmodule

`default_nettype wire

// file: fspi_top.sv
/*
  Pin-level serial slave of a byte-wide nonvolatile memory. Oversamples the
  chip select, serial clock, serial input and write-protect pins, decodes
  commands, and talks to an array behind a simple request port.
  Assumes the array answers a read request within four clock cycles and
  accepts every write strobe; the serial clock is at most a sixteenth of clk_in.
*/
// Operation
// - Deselected: standby, ignore inputs, serial output released.
// - Serial clock edges act only while chip select is low.
// - Inputs captured on rising edges, output changes on falling edges.
// - Serial clock may run slowly or stop; state is held meanwhile.
// - Serial input is sampled only at rising serial clock edges.
// - Output is driven only while returning read data.
// - Guard bit set and write-protect low: status writes are rejected.
// - Floating write-protect reads high, so inactive.
// - Array is 524,288 locations of eight bits.
// - First byte of a frame is the opcode; address and data follow.
// - Unknown opcode: ignore input until next select, output released.
// - Clock low at select means mode 0, high means mode 3.
// - Three address bytes, most significant first; surplus high bits ignored.
`timescale 1ns/1ns
`default_nettype none

module fspi_top (
  // Clock, reset and enable
  input  wire logic                         clk_in,
  input  wire logic                         rst_in,
  input  wire logic                         ce_in,
  // Serial pins
  input  wire logic                         cs_n_in,
  input  wire logic                         sck_in,
  input  wire logic                         si_in,
  input  wire logic                         wp_n_in,
  output logic                              so_out,
  output logic                              so_oe_out,
  // Array port
  output logic                              mem_rd_req_out,
  output logic                              mem_wr_out,
  output logic [fspi_pkg::ADDR_W-1:0]       mem_addr_out,
  output logic [fspi_pkg::DATA_W-1:0]       mem_wdata_out,
  input  wire logic                         mem_rd_valid_in,
  input  wire logic [fspi_pkg::DATA_W-1:0]  mem_rdata_in,
  // State seen from outside
  output logic [7:0]                        status_out,
  output logic                              mode3_out,
  output logic                              standby_out
);
  import fspi_pkg::*;

  // ==========================================================================
  // Pin synchronisers
  logic cs_s1, cs_s2, cs_d, sck_s1, sck_s2, sck_d, si_s1, si_s2, wp_s1, wp_s2;
  logic sel, cs_fall, sck_rise, sck_fall;

  // Reset values equal idle pin levels; write-protect idles high as a pull-up would.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      {cs_s1, cs_s2, cs_d} <= 3'h7;
      {sck_s1, sck_s2, sck_d, si_s1, si_s2} <= 5'h00;
      {wp_s1, wp_s2} <= 2'h3;
    end else if (ce_in) begin
      {cs_s1, cs_s2, cs_d} <= {cs_n_in, cs_s1, cs_s2};
      {sck_s1, sck_s2, sck_d} <= {sck_in, sck_s1, sck_s2};
      {si_s1, si_s2} <= {si_in, si_s1};
      {wp_s1, wp_s2} <= {wp_n_in, wp_s1};
    end
  end

  // Edges come from the settled stages only; the clock may stop at any time.
  assign sel      = !cs_s2;
  assign cs_fall  = cs_d && !cs_s2;
  assign sck_rise = sel && sck_s2 && !sck_d;
  assign sck_fall = sel && !sck_s2 && sck_d;

  // ==========================================================================
  // Read prefetch buffer
  logic             fifo_clr, fifo_pop, fifo_in_ready, fifo_valid, fifo_push;
  logic [DATA_W-1:0] fifo_data;

  // Late answers after deselect are dropped rather than kept for a later frame.
  assign fifo_push = mem_rd_valid_in && sel;

  fspi_fifo #(.W(DATA_W), .D(FIFO_DEPTH)) u_fifo (
    .clk_in        (clk_in),
    .rst_in        (rst_in),
    .ce_in         (ce_in),
    .clr_in        (fifo_clr),
    .in_valid_in   (fifo_push),
    .in_ready_out  (fifo_in_ready),
    .in_data_in    (mem_rdata_in),
    .out_valid_out (fifo_valid),
    .out_ready_in  (fifo_pop),
    .out_data_out  (fifo_data)
  );

  // ==========================================================================
  // Command engine
  fspi_phase_t       phase_r, phase_nxt;
  logic [2:0]        bcnt_r, bcnt_nxt;
  logic [1:0]        acnt_r, acnt_nxt;
  logic [7:0]        sh_in_r, sh_in_nxt, op_r, op_nxt, sh_out_r, sh_out_nxt;
  logic [7:0]        status_r, status_nxt, byte_in, out_byte;
  logic [ADDR_W-1:0] addr_r, addr_nxt, mem_addr_r, mem_addr_nxt;
  logic [DATA_W-1:0] mem_wdata_r, mem_wdata_nxt;
  logic              so_r, so_nxt, so_oe_r, so_oe_nxt, mode3_r, mode3_nxt;
  logic              rd_pend_r, rd_pend_nxt, mem_rd_r, mem_rd_nxt, mem_wr_r, mem_wr_nxt;
  logic              guard_block;

  assign byte_in     = {sh_in_r[6:0], si_s2};
  assign guard_block = status_r[STAT_GUARD_BIT] && !wp_s2;

  // Next state of the whole frame: decode, address, data and output shifting.
  always_comb begin
    phase_nxt     = phase_r;
    bcnt_nxt      = bcnt_r;
    acnt_nxt      = acnt_r;
    sh_in_nxt     = sh_in_r;
    op_nxt        = op_r;
    sh_out_nxt    = sh_out_r;
    status_nxt    = status_r;
    addr_nxt      = addr_r;
    mem_addr_nxt  = mem_addr_r;
    mem_wdata_nxt = mem_wdata_r;
    so_nxt        = so_r;
    so_oe_nxt     = so_oe_r;
    mode3_nxt     = mode3_r;
    rd_pend_nxt   = rd_pend_r && !mem_rd_valid_in;
    mem_rd_nxt    = 1'b0;
    mem_wr_nxt    = 1'b0;
    fifo_clr      = 1'b0;
    fifo_pop      = 1'b0;
    out_byte      = 8'h00;
    if (!sel) begin
      // Standby: every frame counter drops back and the output is released.
      if (phase_r == FSPI_WDATA || phase_r == FSPI_SRWR) begin
        status_nxt[STAT_WEL_BIT] = 1'b0;
      end
      phase_nxt = FSPI_IDLE;
      bcnt_nxt  = 3'h0;
      acnt_nxt  = 2'h0;
      so_oe_nxt = 1'b0;
      fifo_clr  = 1'b1;
    end else if (cs_fall) begin
      mode3_nxt = sck_s2;
      phase_nxt = FSPI_OPCODE;
      bcnt_nxt  = 3'h0;
    end else if (sck_rise) begin
      sh_in_nxt = byte_in;
      bcnt_nxt  = bcnt_r + 3'h1;
      if (bcnt_r == 3'h7) begin
        case (phase_r)
          FSPI_OPCODE: begin
            op_nxt = byte_in;
            case (byte_in)
              OP_WREN: begin
                status_nxt[STAT_WEL_BIT] = 1'b1;
                phase_nxt = FSPI_IGNORE;
              end
              OP_WRDI: begin
                status_nxt[STAT_WEL_BIT] = 1'b0;
                phase_nxt = FSPI_IGNORE;
              end
              OP_RDSR:  phase_nxt = FSPI_SRRD;
              OP_WRSR: begin
                phase_nxt = (guard_block || !status_r[STAT_WEL_BIT]) ?
                            FSPI_IGNORE : FSPI_SRWR;
              end
              OP_READ:  phase_nxt = FSPI_ADDR;
              OP_WRITE: begin
                phase_nxt = status_r[STAT_WEL_BIT] ? FSPI_ADDR : FSPI_IGNORE;
              end
              default:  phase_nxt = FSPI_IGNORE;
            endcase
          end
          FSPI_ADDR: begin
            // Shifting drops the surplus leading bits of the three bytes.
            addr_nxt = {addr_r[ADDR_W-9:0], byte_in};
            acnt_nxt = acnt_r + 2'h1;
            if (acnt_r == 2'(ADDR_BYTES - 1)) begin
              phase_nxt = (op_r == OP_READ) ? FSPI_RDATA : FSPI_WDATA;
            end
          end
          FSPI_WDATA: begin
            mem_wr_nxt    = 1'b1;
            mem_addr_nxt  = addr_r;
            mem_wdata_nxt = byte_in;
            addr_nxt      = addr_r + 1'b1;
          end
          FSPI_SRWR: begin
            status_nxt = (status_r & ~STAT_WR_MASK) | (byte_in & STAT_WR_MASK);
            phase_nxt  = FSPI_IGNORE;
          end
          default: ;
        endcase
      end
    end else if (sck_fall && (phase_r == FSPI_RDATA || phase_r == FSPI_SRRD)) begin
      // A new byte is presented on the falling edge that follows its 8th rise.
      if (bcnt_r == 3'h0) begin
        fifo_pop   = (phase_r == FSPI_RDATA);
        out_byte   = (phase_r == FSPI_SRRD) ? status_r : fifo_data;
        so_nxt     = out_byte[7];
        sh_out_nxt = {out_byte[6:0], 1'b0};
      end else begin
        so_nxt     = sh_out_r[7];
        sh_out_nxt = {sh_out_r[6:0], 1'b0};
      end
      so_oe_nxt = 1'b1;
    end
    // Prefetch keeps the buffer topped up; its ready stalls new requests.
    if (sel && !cs_fall && phase_r == FSPI_RDATA && !rd_pend_r && fifo_in_ready
        && !fifo_pop) begin
      mem_rd_nxt   = 1'b1;
      mem_addr_nxt = addr_r;
      addr_nxt     = addr_r + 1'b1;
      rd_pend_nxt  = 1'b1;
    end
  end

  // Registers only.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      phase_r     <= FSPI_IDLE;
      bcnt_r      <= 3'h0;
      acnt_r      <= 2'h0;
      sh_in_r     <= 8'h00;
      op_r        <= 8'h00;
      sh_out_r    <= 8'h00;
      status_r    <= STAT_RESET;
      addr_r      <= '0;
      mem_addr_r  <= '0;
      mem_wdata_r <= '0;
      so_r        <= 1'b0;
      so_oe_r     <= 1'b0;
      mode3_r     <= 1'b0;
      rd_pend_r   <= 1'b0;
      mem_rd_r    <= 1'b0;
      mem_wr_r    <= 1'b0;
    end else if (ce_in) begin
      phase_r     <= phase_nxt;
      bcnt_r      <= bcnt_nxt;
      acnt_r      <= acnt_nxt;
      sh_in_r     <= sh_in_nxt;
      op_r        <= op_nxt;
      sh_out_r    <= sh_out_nxt;
      status_r    <= status_nxt;
      addr_r      <= addr_nxt;
      mem_addr_r  <= mem_addr_nxt;
      mem_wdata_r <= mem_wdata_nxt;
      so_r        <= so_nxt;
      so_oe_r     <= so_oe_nxt;
      mode3_r     <= mode3_nxt;
      rd_pend_r   <= rd_pend_nxt;
      mem_rd_r    <= mem_rd_nxt;
      mem_wr_r    <= mem_wr_nxt;
    end
  end

  assign so_out         = so_r;
  assign so_oe_out      = so_oe_r;
  assign mem_rd_req_out = mem_rd_r;
  assign mem_wr_out     = mem_wr_r;
  assign mem_addr_out   = mem_addr_r;
  assign mem_wdata_out  = mem_wdata_r;
  assign status_out     = status_r;
  assign mode3_out      = mode3_r;
  assign standby_out    = cs_s2;

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in || !ce_in);

  standby_release_a: assert property (cs_s2 |=> !so_oe_r)
    else $error("serial output driven while deselected");
  drive_read_a: assert property (so_oe_r |-> (phase_r == FSPI_RDATA || phase_r == FSPI_SRRD))
    else $error("serial output driven outside a read");
  out_fall_a: assert property ($changed(so_r) |-> $past(sck_fall))
    else $error("serial output changed away from a falling edge");
  sample_rise_a: assert property (
    ($changed(sh_in_r)) |-> $past(sck_rise) && $past(sel))
    else $error("input shifted without a rising edge");
  frame_reset_a: assert property (cs_s2 |=> phase_r == FSPI_IDLE && bcnt_r == 3'h0)
    else $error("frame state kept after deselect");
  mode_pick_a: assert property (cs_fall |=> mode3_r == $past(sck_s2))
    else $error("clock mode not taken at select");
  guard_reject_a: assert property (
    (phase_r == FSPI_OPCODE && sck_rise && bcnt_r == 3'h7 && byte_in == OP_WRSR
     && guard_block) |=> phase_r != FSPI_SRWR)
    else $error("status write accepted while guarded");
  opcode_take_a: assert property (
    (phase_r == FSPI_OPCODE && sck_rise && bcnt_r == 3'h7) |=> op_r == $past(byte_in))
    else $error("opcode not taken from first byte");
  ignore_quiet_a: assert property (
    phase_r == FSPI_IGNORE && sel |=> (phase_r == FSPI_IGNORE || phase_r == FSPI_IDLE)
    && !so_oe_r)
    else $error("ignored frame resumed or drove output");
  clk_gate_a: assert property (!sel |=> $stable(sh_in_r) && !mem_wr_r)
    else $error("serial clock acted while deselected");

  read_cover_c:  cover property (phase_r == FSPI_RDATA && fifo_pop);
  write_cover_c: cover property (mem_wr_r);
  rdsr_cover_c:  cover property (phase_r == FSPI_SRRD && so_oe_r);
  guard_cover_c: cover property (phase_r == FSPI_OPCODE && bcnt_r == 3'h7 && sck_rise
                                 && byte_in == OP_WRSR && guard_block);

endmodule

`default_nettype wire

// file: fspi_master_model.sv
/*
  Serial master model that drives the pin side of the memory interface.
  Assumes a free-running clk_in; every pin change follows its rising edge.
*/
`timescale 1ns/1ns
`default_nettype none

module fspi_master_model (
  // Clock and returned data
  input  wire logic clk_in,
  input  wire logic so_line_in,
  // Pins driven by the master
  output logic      cs_n_out,
  output logic      sck_out,
  output logic      si_out
);
  // Half period of 80 ns keeps the link well below 20 MHz.
  localparam int HALF = 8;

  // Pins start deselected with the clock parked low.
  initial begin
    cs_n_out = 1'b1;
    sck_out  = 1'b0;
    si_out   = 1'b0;
  end

  // Wait a number of clock cycles.
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
  endtask

  // Park the clock at the mode level first, then select with one falling edge.
  task automatic begin_frame(input bit m3);
    tick(1);
    sck_out <= m3;
    tick(4);
    cs_n_out <= 1'b0;
    tick(HALF);
  endtask

  // Data is set while the clock is low and returned data is taken at the rise.
  task automatic xfer(input logic [7:0] tx, input int nb, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - nb; i--) begin
      sck_out <= 1'b0;
      si_out  <= tx[i];
      tick(HALF);
      rx[i] = so_line_in;
      sck_out <= 1'b1;
      tick(HALF);
    end
  endtask

  // Return the clock to its idle level, deselect, and leave a changed data level.
  task automatic end_frame(input bit m3);
    sck_out <= m3;
    tick(HALF);
    cs_n_out <= 1'b1;
    tick(1);
    si_out <= ~si_out;
    tick(HALF);
  endtask

  // Toggle clock and data while deselected; an even count ends with the clock low.
  task automatic noise(input int n);
    repeat (n) begin
      sck_out <= ~sck_out;
      si_out  <= 1'($urandom);
      tick(HALF);
    end
  endtask
endmodule

`default_nettype wire

// file: fspi_top_bench.sv
/*
  Self-checking bench of the serial memory pin interface with an array model.
  Assumes the master model drives the pins and the array answers in 1..4 cycles.
*/
`timescale 1ns/1ns
`default_nettype none

module fspi_top_bench;
  import fspi_pkg::*;

  // ==========================================================================
  // Signals and models
  logic              clk_in = 1'b0;
  logic              rst_in = 1'b1;
  logic              ce_in = 1'b1;
  logic              wp_n_in = 1'b1;
  logic              so_float = 1'b0;
  logic              cs_n, sck, si, so_out, so_oe_out, so_line;
  logic              mem_rd_req_out, mem_wr_out, mode3_out, standby_out;
  logic              mem_rd_valid_in;
  logic [ADDR_W-1:0] mem_addr_out;
  logic [7:0]        mem_wdata_out, mem_rdata_in, status_out;
  logic [7:0]        mem [0:(1<<ADDR_W)-1];
  logic [ADDR_W-1:0] ra_pipe [0:3];
  logic [3:0]        rq_pipe = 4'h0;
  logic [26:0]       exp_wr [$];
  logic [7:0]        rxq [$];
  logic [7:0]        wv [4] = '{8'h8c, 8'h00, 8'h00, 8'hff};
  int                lat = 1, n_wr = 0, n_rd = 0, oe_cnt = 0;
  int                n_errors = 0, num_checks = 0;

  // The released output line shows a level that changes every cycle.
  assign so_line = so_oe_out ? so_out : so_float;
  assign mem_rd_valid_in = rq_pipe[lat-1];
  assign mem_rdata_in = mem[ra_pipe[lat-1]];

  always #5 clk_in = ~clk_in;

  fspi_master_model m (.clk_in(clk_in), .so_line_in(so_line), .cs_n_out(cs_n),
                       .sck_out(sck), .si_out(si));

  fspi_top uut (.clk_in(clk_in), .rst_in(rst_in), .ce_in(ce_in), .cs_n_in(cs_n),
    .sck_in(sck), .si_in(si), .wp_n_in(wp_n_in), .so_out(so_out),
    .so_oe_out(so_oe_out), .mem_rd_req_out(mem_rd_req_out), .mem_wr_out(mem_wr_out),
    .mem_addr_out(mem_addr_out), .mem_wdata_out(mem_wdata_out),
    .mem_rd_valid_in(mem_rd_valid_in), .mem_rdata_in(mem_rdata_in),
    .status_out(status_out), .mode3_out(mode3_out), .standby_out(standby_out));

  // ==========================================================================
  // Checking helpers
  task automatic check(string what, logic [31:0] exp, logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Status after a register write; the guard holds while write-protect is low.
  function automatic logic [7:0] next_status(logic [7:0] old, logic [7:0] v, logic wp);
    if (old[STAT_GUARD_BIT] && !wp) return old;
    return (old & ~STAT_WR_MASK) | (v & STAT_WR_MASK);
  endfunction

  // Array model: delayed read answers, stored writes checked in order.
  always @(posedge clk_in) begin
    rq_pipe <= {rq_pipe[2:0], mem_rd_req_out};
    ra_pipe[0] <= mem_addr_out;
    for (int i = 1; i < 4; i++) ra_pipe[i] <= ra_pipe[i-1];
    so_float <= ~so_float;
    if (so_oe_out) oe_cnt <= oe_cnt + 1;
    if (mem_rd_req_out) n_rd <= n_rd + 1;
    if (mem_wr_out) begin
      mem[mem_addr_out] <= mem_wdata_out;
      n_wr <= n_wr + 1;
      check("write", exp_wr.size() ? exp_wr.pop_front() : 'x, {mem_addr_out, mem_wdata_out});
    end
  end

  // One whole frame: command bytes, then a number of read bytes with a pause.
  task automatic run_frame(input bit m3, input logic [7:0] tx [$], input int nrd);
    logic [7:0] b;
    rxq = {};
    m.begin_frame(m3);
    foreach (tx[i]) m.xfer(tx[i], 8, b);
    if (nrd > 0) check("oe early", 0, so_oe_out);
    for (int i = 0; i < nrd; i++) begin
      m.xfer(8'($urandom), 8, b);
      rxq.push_back(b);
      // Freeze the block while the serial clock is parked; nothing may be lost.
      if (i == 1) begin
        ce_in <= 1'b0;
        m.tick(40 + $urandom % 60);
        ce_in <= 1'b1;
      end
    end
    m.end_frame(m3);
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    logic [7:0]        a [3];
    logic [7:0]        d, op;
    logic [ADDR_W-1:0] ad;
    logic [7:0]        wd [$];
    logic [7:0]        st;
    int                n, n0;
    void'($urandom(23659));
    repeat (3) @(posedge clk_in);
    rst_in <= 1'b0;
    repeat (4) @(posedge clk_in);
    check("status", STAT_RESET, status_out);
    check("standby", 1, standby_out);
    m.noise(20);
    m.tick(8);
    check("deselected", 0, n_wr + n_rd + oe_cnt);
    // Write a run of bytes, then read it back in the other clock mode.
    for (int r = 0; r < 2; r++) begin
      run_frame(r[0], {OP_WREN}, 0);
      check("wel", 1, status_out[STAT_WEL_BIT]);
      check("mode", r, mode3_out);
      foreach (a[i]) a[i] = 8'($urandom);
      n = 3 + $urandom % 4;
      wd = {};
      for (int i = 0; i < n; i++) begin
        d = 8'($urandom);
        wd.push_back(d);
        ad = ADDR_W'({a[0], a[1], a[2]}) + ADDR_W'(i);
        exp_wr.push_back({ad, d});
      end
      n0 = n_wr;
      // An empty write frame spends the latch, so the next write is refused.
      run_frame(!r[0], {OP_WRITE, a[0], a[1], a[2]}, 0);
      check("wel spent", 0, status_out[STAT_WEL_BIT]);
      run_frame(r[0], {OP_WRITE, a[0], a[1], a[2], wd}, 0);
      check("refused", n0, n_wr);
      run_frame(r[0], {OP_WREN}, 0);
      run_frame(!r[0], {OP_WRITE, a[0], a[1], a[2], wd}, 0);
      check("writes", n0 + n, n_wr);
      check("mode", !r[0], mode3_out);
      check("wel clr", 0, status_out[STAT_WEL_BIT]);
      check("no out", 0, oe_cnt);
      lat = 1 + $urandom % 4;
      run_frame(r[0], {OP_READ, a[0], a[1], a[2]}, n);
      foreach (wd[i]) check("read", wd[i], rxq[i]);
      oe_cnt = 0;
    end
    // Unknown opcodes leave the array and output untouched.
    run_frame(0, {OP_WREN}, 0);
    for (int k = 0; k < 3; k++) begin
      n0 = n_wr + n_rd + oe_cnt;
      do op = 8'($urandom);
      while (op inside {OP_WREN, OP_WRDI, OP_RDSR, OP_WRSR, OP_READ, OP_WRITE});
      run_frame(k[0], {op, 8'h00, 8'h00, 8'h00, op, ~op}, 0);
      check("bad op", n0, n_wr + n_rd + oe_cnt);
    end
    // A partial byte is dropped and the next frame starts afresh.
    m.begin_frame(0);
    m.xfer(OP_WRDI, 5, d);
    m.end_frame(0);
    check("partial", 1, status_out[STAT_WEL_BIT]);
    run_frame(0, {OP_WRDI}, 0);
    check("wrdi", 0, status_out[STAT_WEL_BIT]);
    // Status writes against the guard bit and write-protect pin.
    st = STAT_RESET;
    for (int k = 0; k < 4; k++) begin
      wp_n_in <= ~k[0];
      run_frame(0, {OP_WREN}, 0);
      run_frame(1, {OP_WRSR, wv[k]}, 0);
      st = next_status(st, wv[k], ~k[0]);
      check("status", st & STAT_WR_MASK, status_out & STAT_WR_MASK);
      run_frame(k[1], {OP_RDSR}, 2);
      check("rdsr", st & STAT_WR_MASK, rxq[1] & STAT_WR_MASK);
    end
    finish_test();
  end

  // Watchdog well beyond the expected run length.
  initial begin
    repeat (90000) @(posedge clk_in);
    n_errors++;
    $display("BAD watchdog expected done seen timeout");
    finish_test();
  end
endmodule

`default_nettype wire
